// ===== logic/lkd_top.sv
/*
  lcd key/control decoder: serial receiver for display and control
  bits, triplexed segment/common timing, key-matrix scan and key
  read-back, small interrupt register port.
  assumes: serial pins and sense inputs asynchronous to mclk; the link
  clock much slower than mclk (32 ns); an external pull-up on serial
  output; analogue drive levels are built outside from seg/com bits.
*/
// Design decisions made here: the strobed register port and the placing of the registers.
// What this block does
// - either sleep bit set means sleep, osc stopped, segments and commons low
// - idle scan lines follow sleep pair: 00/11 all high, 01 sixth, 10 fifth+sixth
// - sleep ends only on a control write with both sleep bits zero
// - a key press in sleep restarts the oscillator for a scan
// - scan-pin code sets first two scan lines as scan or segment
// - key bits of rows used as segments read zero
// - port code turns first zero to four segment pins into ports
// - port pins drive static level of first bit of their triplet
// - port pins keep following their bits during sleep
// - blank bit gives segment-off waveforms, commons keep running
// - bias bit chooses one-third (0) or one-half (1) bias
// - display bits map in triplets to pins, one bit per common
// - a one lights the segment at its pin and common
// - pressed key sets bit (row-1)*5+column, thirty bits
// - sleep ack holds mode at key press; pending mode writes apply
// - serial output low after debounce, cleared by read, high in transfer except while read data bits shift out
// - common frame is oscillator over 384
`timescale 1ns/1ps
module lkd_top
  import lkd_pkg::*;
#(
  parameter int OSC_DIVP = lkd_pkg::OSC_DIV  // mclk cycles per osc period
)
(
  input  wire logic                      mclk,            // core clock
  input  wire logic                      rst_n,           // sync reset
  input  wire logic                      ce_pin,          // chip enable
  input  wire logic                      serial_clock_in, // link clock
  input  wire logic                      serial_in,       // link data
  input  wire logic [lkd_pkg::N_COL-1:0] sense_inputs,    // key columns
  output logic                           serial_out_o,    // always low
  output logic                           serial_out_oe,   // pull low
  output logic [lkd_pkg::N_ROW-1:0]      scan_lines,      // key rows
  output logic [lkd_pkg::N_SEG-1:0]      seg_out,         // segment bits
  output logic [lkd_pkg::N_COM-1:0]      com_out,         // common bits
  output logic                           bias_half,       // half bias
  output logic                           osc_run,         // osc enabled
  input  wire logic [1:0]                reg_addr,        // reg address
  input  wire logic [7:0]                reg_wdata,       // write data
  input  wire logic                      reg_wr,          // write strobe
  input  wire logic                      reg_rd,          // read strobe
  output logic [7:0]                     reg_rdata,       // read data
  output logic                           irq              // interrupt
);
  import lkd_pkg::*;

  // usable scan rows for a scan-pin code
  function automatic logic [N_ROW-1:0] row_en(input logic [1:0] k);
    if (k[1])
      return 6'b11_1100;
    else if (k[0])
      return 6'b11_1110;
    return 6'b11_1111;
  endfunction

  // pin i is a static port for port code p
  function automatic logic gp_pin(input logic [2:0] p, input int i);
    return (p <= 3'h4) && (i < int'(p));
  endfunction

  // pin synchronisers, stage 3 only feeds edge detection
  logic [2:0]       ce_sy;
  logic [2:0]       ck_sy;
  logic [1:0]       di_sy;
  logic [N_COL-1:0] si_m;
  logic [N_COL-1:0] si_s;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ce_sy <= '0;
      ck_sy <= '0;
      di_sy <= '0;
      si_m  <= '0;
      si_s  <= '0;
    end
    else
    begin
      ce_sy <= {ce_sy[1:0], ce_pin};
      ck_sy <= {ck_sy[1:0], serial_clock_in};
      di_sy <= {di_sy[0], serial_in};
      si_m  <= sense_inputs;
      si_s  <= si_m;
    end
  end

  logic ce_s;
  logic ce_rise;
  logic ce_fall;
  logic ck_rise;
  assign ce_s    = ce_sy[1];
  assign ce_rise = ce_sy[1] & ~ce_sy[2];
  assign ce_fall = ~ce_sy[1] & ce_sy[2];
  assign ck_rise = ck_sy[1] & ~ck_sy[2];

  // key state, declared early for the read-back word
  lkd_kst_e         kst;
  logic [N_KEY-1:0] key_reg;
  logic             ack_reg;
  logic             req_reg;

  // read-back order: first key bit first, sleep ack last
  logic [N_KEY:0] rd_word;
  always_comb
  begin
    rd_word[0] = ack_reg;
    for (int i = 0; i < N_KEY; i++)
      rd_word[N_KEY-i] = key_reg[i];
  end

  // serial receiver and read shifter, all on link clock rises
  logic [OP_W-1:0]  op_reg;
  logic [PAY_W-1:0] sh_reg;
  logic [6:0]       bcnt_reg;
  logic             rd_act;
  logic [N_KEY:0]   osh_reg;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      op_reg   <= '0;
      sh_reg   <= '0;
      bcnt_reg <= '0;
      rd_act   <= 1'b0;
      osh_reg  <= '0;
    end
    else if (ce_rise)
    begin
      bcnt_reg <= '0;
      rd_act   <= 1'b0;
    end
    else if (ce_fall)
      rd_act <= 1'b0;
    else if (ce_s && ck_rise)
    begin
      if (bcnt_reg < 7'(OP_W))
        op_reg <= {op_reg[OP_W-2:0], di_sy[1]};
      else
        sh_reg <= {sh_reg[PAY_W-2:0], di_sy[1]};
      if (bcnt_reg != 7'h7F)
        bcnt_reg <= bcnt_reg + 7'h01;
      // read data loads as the op byte completes
      if (bcnt_reg == 7'(OP_W-1) && {op_reg[OP_W-2:0], di_sy[1]} == OP_READ)
      begin
        rd_act  <= 1'b1;
        osh_reg <= rd_word;
      end
      else if (rd_act)
        osh_reg <= {osh_reg[N_KEY-1:0], 1'b0};
    end
  end

  logic wr_done;
  logic rd_done;
  assign wr_done = ce_fall && op_reg == OP_WRITE && bcnt_reg == WR_BITS;
  assign rd_done = ce_fall && op_reg == OP_READ && bcnt_reg >= RD_BITS;

  // all fields land in one edge; short frames are dropped
  logic [N_CTRL-1:0] ctrl_reg;
  logic [N_DISP-1:0] disp_reg;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= CTRL_RST;
      disp_reg <= '0;
    end
    else if (wr_done)
    begin
      for (int i = 0; i < N_DISP; i++)
        disp_reg[i] <= sh_reg[PAY_W-1-i];
      for (int j = 0; j < N_CTRL; j++)
        ctrl_reg[j] <= sh_reg[N_CTRL-1-j];
    end
  end

  logic       sleep;
  logic [1:0] ssel;
  logic [1:0] ksel;
  logic [2:0] psel;
  logic       blank;
  logic [N_ROW-1:0] ren;
  assign sleep = ctrl_reg[CB_SA] | ctrl_reg[CB_SB];
  assign ssel  = {ctrl_reg[CB_SA], ctrl_reg[CB_SB]};
  assign ksel  = {ctrl_reg[CB_KA], ctrl_reg[CB_KB]};
  assign psel  = {ctrl_reg[CB_PA], ctrl_reg[CB_PB], ctrl_reg[CB_PC]};
  assign blank = ctrl_reg[CB_BL];
  assign ren   = row_en(ksel);

  // emulated rc oscillator; runs in sleep only from a key press until the scan ends idle or the key is read
  logic       osc_on;
  logic [7:0] dcnt;
  logic       tick;
  assign osc_on = !sleep || kst != K_IDLE;
  assign tick   = osc_on && dcnt == 8'(OSC_DIVP - 1);
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !osc_on || tick)
      dcnt <= '0;
    else
      dcnt <= dcnt + 8'h01;
  end

  // frame timing: three common phases, polarity flips per frame
  logic [6:0] pcnt;
  logic [1:0] com_idx;
  logic       pol;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pcnt    <= '0;
      com_idx <= '0;
      pol     <= 1'b0;
    end
    else if (tick && !sleep)
    begin
      pcnt <= pcnt + 7'h01;
      if (pcnt == 7'(PHASE_T-1))
      begin
        pcnt <= '0;
        if (com_idx == 2'(N_COM-1))
        begin
          com_idx <= '0;
          pol     <= ~pol;
        end
        else
          com_idx <= com_idx + 2'h1;
      end
    end
  end

  // key scan: two passes of six rows, agree, then request at REQ_T
  logic [5:0]       rcnt;
  logic [2:0]       row;
  logic             pass;
  logic [9:0]       tcnt;
  logic [N_KEY-1:0] b1;
  logic [N_KEY-1:0] b2;
  logic [N_COL-1:0] samp;
  assign samp = ren[row] ? si_s : '0;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      kst     <= K_IDLE;
      rcnt    <= '0;
      row     <= '0;
      pass    <= 1'b0;
      tcnt    <= '0;
      b1      <= '0;
      b2      <= '0;
      key_reg <= '0;
      ack_reg <= 1'b0;
      req_reg <= 1'b0;
    end
    else
    begin
      unique case (kst)
        K_IDLE:
          if (|si_s)
          begin
            kst  <= K_SCAN;
            rcnt <= '0;
            row  <= '0;
            pass <= 1'b0;
            tcnt <= '0;
            ack_reg <= sleep;
          end
        K_SCAN:
          if (tick)
          begin
            tcnt <= tcnt + 10'h001;
            rcnt <= rcnt + 6'h01;
            if (rcnt == 6'(ROW_T-1))
            begin
              rcnt <= '0;
              if (pass)
                b2[row*N_COL +: N_COL] <= samp;
              else
                b1[row*N_COL +: N_COL] <= samp;
              if (row == 3'(N_ROW-1))
              begin
                row  <= '0;
                pass <= 1'b1;
                if (pass)
                  kst <= K_WAIT;
              end
              else
                row <= row + 3'h1;
            end
          end
        K_WAIT:
          if (tick)
          begin
            tcnt <= tcnt + 10'h001;
            if (tcnt == 10'(REQ_T-1))
            begin
              if (b1 == b2 && |b2)
              begin
                kst     <= K_HELD;
                key_reg <= b2;
                req_reg <= 1'b1;
              end
              else if (|b2)
              begin
                kst  <= K_SCAN;
                tcnt <= '0;
                pass <= 1'b0;
              end
              else
                kst <= K_IDLE;
            end
          end
        K_HELD:
          if (rd_done)
          begin
            req_reg <= 1'b0;
            kst     <= K_IDLE;
          end
      endcase
    end
  end

  // standby pattern of the scan lines
  logic [N_ROW-1:0] stby;
  always_comb
  begin
    unique case (ssel)
      2'b01:   stby = 6'b10_0000;
      2'b10:   stby = 6'b11_0000;
      default: stby = 6'b11_1111;
    endcase
  end

  // segment pin levels: port, forced low, or lit xor polarity
  logic [N_SEG-1:0] seg_next;
  logic             com_sel0;
  generate
    for (genvar g = 0; g < N_SEG; g++)
    begin : g_seg
      logic lit;
      logic is_seg;
      assign lit = ~blank & disp_reg[3*g + com_idx];
      if (g >= N_SEG - 2)
        assign is_seg = !ren[g - (N_SEG - 2)];
      else
        assign is_seg = 1'b1;
      if (g < N_GP)
        assign seg_next[g] = gp_pin(psel, g) ? disp_reg[3*g] :
                             (is_seg && !sleep) ? lit ^ pol : 1'b0;
      else
        assign seg_next[g] = (is_seg && !sleep) ? lit ^ pol : 1'b0;
    end
  endgenerate
  assign com_sel0 = 1'b0;

  // pin outputs; the serial output only ever pulls low
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      seg_out       <= '0;
      com_out       <= '0;
      scan_lines    <= '0;
      serial_out_oe <= 1'b0;
      serial_out_o  <= 1'b0;
      bias_half     <= 1'b0;
      osc_run       <= 1'b0;
    end
    else
    begin
      seg_out      <= seg_next;
      serial_out_o <= com_sel0;
      bias_half    <= ctrl_reg[CB_BI];
      osc_run      <= osc_on;
      // commons keep running while blanked, low in sleep
      if (sleep)
        com_out <= '0;
      else
        com_out <= (3'h1 << com_idx) ^ {N_COM{pol}};
      if (kst == K_SCAN)
        scan_lines <= (6'h01 << row) & ren;
      else
        scan_lines <= (sleep ? stby : 6'b11_1111) & ren;
      // data bits during a read, released in other transfers, request level while ce is low
      if (ce_s)
        serial_out_oe <= rd_act & ~osh_reg[N_KEY];
      else
        serial_out_oe <= req_reg;
    end
  end

  // sticky status, set beats a same-cycle clear
  logic [N_EV-1:0] ev;
  logic [N_EV-1:0] stat_reg;
  logic [N_EV-1:0] en_reg;
  logic [N_EV-1:0] clr;
  assign ev[EV_REQ]  = kst == K_WAIT && tick && tcnt == 10'(REQ_T-1)
                       && b1 == b2 && |b2;
  assign ev[EV_CFG]  = wr_done;
  assign ev[EV_WAKE] = kst == K_IDLE && |si_s && sleep;
  assign clr = (reg_wr && reg_addr == A_CLR) ? reg_wdata[N_EV-1:0] : '0;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stat_reg  <= '0;
      en_reg    <= '0;
      irq       <= 1'b0;
      reg_rdata <= '0;
    end
    else
    begin
      stat_reg <= (stat_reg & ~clr) | ev;
      irq      <= |(stat_reg & en_reg);
      if (reg_wr && reg_addr == A_EN)
        en_reg <= reg_wdata[N_EV-1:0];
      reg_rdata <= '0;
      if (reg_rd)
      begin
        unique case (reg_addr)
          A_STAT:  reg_rdata <= {5'h00, stat_reg};
          A_EN:    reg_rdata <= {5'h00, en_reg};
          A_INFO:  reg_rdata <= {req_reg, sleep, ksel, psel, blank};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // checks
  sleep_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sleep |=> com_out == '0 && seg_out[N_SEG-3:N_GP] == '0)
    else $error("outputs not low in sleep");

  standby_a: assert property (@(posedge mclk) disable iff (!rst_n)
    kst != K_SCAN && ssel == 2'b01 && ksel == 2'b00
    |=> scan_lines == 6'b10_0000)
    else $error("sleep standby scan lines wrong");

  wake_osc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    kst == K_IDLE && sleep && |si_s |=> ##1 osc_run)
    else $error("oscillator not restarted by key");

  seg_rows_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(req_reg) && $past(ksel[1]) |-> key_reg[2*N_COL-1:0] == '0)
    else $error("segment rows reported keys");

  port_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
    psel == 3'h4 |=> seg_out[3] == $past(disp_reg[9]))
    else $error("port pin level wrong");

  blank_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    blank && !sleep && !gp_pin(psel, 4) |=> seg_out[4] == $past(pol)
    && com_out != '0)
    else $error("blanking wrong");

  bias_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 bias_half == $past(ctrl_reg[CB_BI]))
    else $error("bias output does not follow bias bit");

  busy_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce_s && !rd_act |=> !serial_out_oe)
    else $error("serial output low during transfer");

  req_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_done && req_reg |=> !req_reg ##1 !serial_out_oe || ce_s)
    else $error("request not cleared by read");

  commit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_done |=> $stable(ctrl_reg))
    else $error("control changed outside write end");

  ack_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    kst == K_IDLE && |si_s |=> ack_reg == $past(sleep))
    else $error("sleep ack wrong");

endmodule

// ===== logic/lkd_pkg.sv
/*
  constants, field positions and types shared by the lcd key/control
  decoder. assumes a single 250 MHz core clock; every time below is
  counted in periods of the emulated rc oscillator, except OSC_DIV in mclk cycles.
*/
package lkd_pkg;

  // geometry of the display and of the key matrix
  localparam int N_DISP = 75;
  localparam int N_CTRL = 9;
  localparam int PAY_W  = N_DISP + N_CTRL;
  localparam int N_SEG  = 25;
  localparam int N_COM  = 3;
  localparam int N_GP   = 4;
  localparam int N_ROW  = 6;
  localparam int N_COL  = 5;
  localparam int N_KEY  = N_ROW * N_COL;

  // serial frame: one op byte, then payload or read-back
  localparam int OP_W = 8;
  localparam logic [7:0] OP_WRITE = 8'h0A;  // arbitrary value
  localparam logic [7:0] OP_READ  = 8'h0B;  // arbitrary value
  localparam logic [6:0] WR_BITS  = 7'(OP_W + PAY_W);
  localparam logic [6:0] RD_BITS  = 7'(OP_W + N_KEY + 1);

  // control word bit positions, first received bit is CB_SA
  localparam int CB_SA = 0;
  localparam int CB_SB = 1;
  localparam int CB_KA = 2;
  localparam int CB_KB = 3;
  localparam int CB_PA = 4;
  localparam int CB_PB = 5;
  localparam int CB_PC = 6;
  localparam int CB_BL = 7;
  localparam int CB_BI = 8;
  localparam logic [N_CTRL-1:0] CTRL_RST = 9'h000;

  // oscillator-period timing
  localparam int FRAME_T = 384;
  localparam int PHASE_T = FRAME_T / N_COM;
  localparam int SCAN_T  = 288;
  localparam int ROW_T   = SCAN_T / N_ROW;
  localparam int REQ_T   = 615;
  localparam int OSC_DIV = 4;

  // software port map and status bits
  localparam logic [1:0] A_STAT = 2'h0;
  localparam logic [1:0] A_CLR  = 2'h1;
  localparam logic [1:0] A_EN   = 2'h2;
  localparam logic [1:0] A_INFO = 2'h3;
  localparam int EV_REQ  = 0;
  localparam int EV_CFG  = 1;
  localparam int EV_WAKE = 2;
  localparam int N_EV    = 3;

  typedef enum logic [1:0] {K_IDLE, K_SCAN, K_WAIT, K_HELD} lkd_kst_e;

endpackage

// ===== bench/lkd_host.sv
/*
  controller model for the three-wire link: write and read frames.
  assumes mclk at 4 ns, link clock 32 ns idle low, pull-up on data out.
*/
`timescale 1ns/1ps
module lkd_host
  import lkd_pkg::*;
(
  input  wire logic mclk,            // core clock
  input  wire logic serial_out_o,    // device data out
  input  wire logic serial_out_oe,   // device pulls low
  output logic      ce_pin,          // chip enable
  output logic      serial_clock_in, // link clock
  output logic      serial_in        // link data
);
  logic line;

  // open-drain wire, the pull-up wins when nobody drives
  assign line = serial_out_oe ? serial_out_o : 1'b1;

  initial
  begin
    ce_pin = 1'b0;
    serial_clock_in = 1'b0;
    serial_in = 1'b0;
  end

  // half of a 32 ns link period
  task automatic half();
    repeat (4) @(posedge mclk);
  endtask

  // op msb first, then n payload bits; line sampled before each rise
  task automatic frame(input logic [7:0] op, input logic [83:0] pay,
                       input int n, output logic [30:0] got,
                       output logic req, output logic low);
    logic b;
    got = '0;
    low = 1'b0;
    req = ~line;
    ce_pin <= 1'b1;
    half();
    for (int i = 0; i < OP_W + n; i++)
    begin
      b = (i < OP_W) ? op[OP_W-1-i] : pay[i-OP_W];
      serial_in <= b;
      half();
      if (i >= OP_W && i - OP_W < 31)
        got[i-OP_W] = line;
      if (op == OP_WRITE && !line)
        low = 1'b1;
      serial_clock_in <= 1'b1;
      half();
      serial_clock_in <= 1'b0;
    end
    half();
    ce_pin <= 1'b0;
    serial_in <= ~b;  // inverted: never leave the last bit standing
  endtask
endmodule

// ===== bench/test_lcd_key_control_decode.sv
/*
  self-checking bench for the lcd key/control decoder.
  assumes lkd_host as link partner and a diode key matrix model here.
*/
`timescale 1ns/1ps
module test_lcd_key_control_decode;
  import lkd_pkg::*;

  typedef struct packed
  {
    logic [8:0] ctrl;
    logic [5:0] scan;
    logic       osc;
    logic       bias;
    logic [3:0] ports;
  } lkd_row_s;

  localparam int DIVP = 2;
  localparam logic [74:0] DISP  = 75'h5AE_9A5C_3E1F_0B72_D245;
  localparam logic [83:0] RDPAY = {42{2'b10}};

  logic        mclk         = 1'b0;
  logic        rst_n        = 1'b0;
  logic [4:0]  sense_inputs = 5'h00;
  logic [1:0]  reg_addr     = 2'h0;
  logic [7:0]  reg_wdata    = 8'h00;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [29:0] keys         = 30'h0000_0000;
  logic        ce_pin, serial_clock_in, serial_in;
  logic        serial_out_o, serial_out_oe, bias_half, osc_run, irq;
  logic [5:0]  scan_lines;
  logic [24:0] seg_out;
  logic [2:0]  com_out;
  logic [7:0]  reg_rdata;
  logic [30:0] got;
  logic        req, low;
  logic [8:0]  c;
  logic [2:0]  ph;
  int          miscompares, checks_done, cyc, plen;

  // control word, idle rows, osc, bias, sleeping port levels
  lkd_row_s rows [13] = '{
    '{9'h000, 6'h3F, 1'b1, 1'b0, 4'h0}, '{9'h002, 6'h20, 1'b0, 1'b0, 4'h0},
    '{9'h001, 6'h30, 1'b0, 1'b0, 4'h0}, '{9'h003, 6'h3F, 1'b0, 1'b0, 4'h0},
    '{9'h008, 6'h3E, 1'b1, 1'b0, 4'h0}, '{9'h004, 6'h3C, 1'b1, 1'b0, 4'h0},
    '{9'h00C, 6'h3C, 1'b1, 1'b0, 4'h0}, '{9'h100, 6'h3F, 1'b1, 1'b1, 4'h0},
    '{9'h042, 6'h20, 1'b0, 1'b0, 4'h1}, '{9'h022, 6'h20, 1'b0, 1'b0, 4'h1},
    '{9'h062, 6'h20, 1'b0, 1'b0, 4'h5}, '{9'h012, 6'h20, 1'b0, 1'b0, 4'hD},
    '{9'h052, 6'h20, 1'b0, 1'b0, 4'h0}};

  lkd_top #(.OSC_DIVP(DIVP)) dut (
    .mclk(mclk), .rst_n(rst_n), .ce_pin(ce_pin),
    .serial_clock_in(serial_clock_in), .serial_in(serial_in),
    .sense_inputs(sense_inputs), .serial_out_o(serial_out_o),
    .serial_out_oe(serial_out_oe), .scan_lines(scan_lines),
    .seg_out(seg_out), .com_out(com_out), .bias_half(bias_half),
    .osc_run(osc_run), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  lkd_host host (
    .mclk(mclk), .serial_out_o(serial_out_o),
    .serial_out_oe(serial_out_oe), .ce_pin(ce_pin),
    .serial_clock_in(serial_clock_in), .serial_in(serial_in));

  initial
  begin
    forever #2 mclk = ~mclk;
  end

  // key matrix: a closed key ties its row line to its column
  always @(posedge mclk)
  begin
    for (int k = 0; k < N_COL; k++)
      sense_inputs[k] <= |(scan_lines & {keys[25+k], keys[20+k],
                           keys[15+k], keys[10+k], keys[5+k], keys[k]});
  end

  // hang guard, far above the expected run length
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task end_of_test();
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rw(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rr(input logic [1:0] a, input logic [7:0] e,
                    input string n);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask

  task automatic wr_cfg(input logic [8:0] cw);
    host.frame(OP_WRITE, {cw, DISP}, PAY_W, got, req, low);
    repeat (8) @(posedge mclk);
    #1;
  endtask

  task automatic wait_oe(input logic v);
    for (int i = 0; i < 4000 && serial_out_oe !== v; i++)
      @(posedge mclk);
    #1;
  endtask

  // press, wait for the request, release, optional write, read back
  task automatic key_read(input logic [29:0] k, input logic [30:0] e,
                          input logic mid, input string n);
    @(posedge mclk);
    keys <= k;
    wait_oe(1'b1);
    chk("req", serial_out_oe, 1);
    chk("osc_key", osc_run, 1);
    chk("irq_key", irq, 1);
    rr(A_STAT, {5'h00, e[30], 2'b01}, "stat_key");
    @(posedge mclk);
    keys <= 30'h0000_0000;
    if (mid)
    begin
      wr_cfg(9'h000);
      chk("busy_high", low, 0);
      chk("req_kept", serial_out_oe, 1);
    end
    host.frame(OP_READ, RDPAY, N_KEY + 1, got, req, low);
    chk("req_seen", req, 1);
    chk(n, got, e);
    wait_oe(1'b0);
    chk("req_clr", serial_out_oe, 0);
    chk("osc_wake", osc_run, 1);
    rw(A_CLR, 8'h07);
  endtask

  // shows the mapped frame: odd common gives the active one
  task automatic disp_chk(input logic blank);
    logic [2:0]  cs;
    logic        pol;
    logic [24:0] e;
    int          sel, runs;
    runs = 0;
    sel = 0;
    repeat (60)
    begin
      repeat (16) @(posedge mclk);
      #1 cs = com_out;
      @(posedge mclk);
      #1;
      if (cs === com_out && cs != 3'h0 && cs != 3'h7)
      begin
        pol = (cs == 3'h6 || cs == 3'h5 || cs == 3'h3);
        for (int j = 0; j < 3; j++)
          if (cs[j] != pol)
            sel = j;
        for (int p = 0; p < N_SEG; p++)
          e[p] = (~blank & DISP[3*p+sel]) ^ pol;
        chk("seg_wave", seg_out, e);
        runs++;
      end
    end
    chk("com_run", runs > 0, 1);
  endtask

  initial
  begin
    repeat (8) @(posedge mclk);
    #1 chk("rst_osc", osc_run, 0);
    chk("rst_seg", seg_out, 0);
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk("osc_up", osc_run, 1);
    // ordinary configuration cases
    foreach (rows[i])
    begin
      wr_cfg(rows[i].ctrl);
      c = rows[i].ctrl;
      chk("scan", scan_lines, rows[i].scan);
      chk("osc", osc_run, rows[i].osc);
      chk("bias", bias_half, rows[i].bias);
      if (!rows[i].osc)
      begin
        chk("slp_seg", seg_out, {21'h0, rows[i].ports});
        chk("slp_com", com_out, 0);
      end
      rr(A_INFO, {1'b0, c[0] | c[1], c[2], c[3], c[4], c[5], c[6], c[7]},
         "info");
    end
    // a frame one bit short is dropped whole
    host.frame(OP_WRITE, {9'h1FF, DISP}, PAY_W - 1, got, req, low);
    repeat (8) @(posedge mclk);
    #1 chk("short", scan_lines, 6'h20);
    // register port and interrupt mask
    rw(A_EN, 8'h00);
    #1 chk("irq_mask", irq, 0);
    rr(A_STAT, 8'h02, "stat");
    rw(A_STAT, 8'hFF);
    rr(A_STAT, 8'h02, "stat_ro");
    rr(A_CLR, 8'h00, "unmapped");
    rw(A_EN, 8'h07);
    repeat (2) @(posedge mclk);
    #1 chk("irq_on", irq, 1);
    rr(A_EN, 8'h07, "en");
    rw(A_CLR, 8'h02);
    repeat (2) @(posedge mclk);
    #1 chk("irq_off", irq, 0);
    rr(A_STAT, 8'h00, "stat_clr");
    // display mapping, then blanking
    wr_cfg(9'h004);
    disp_chk(1'b0);
    // a common phase is one third of the frame
    ph = com_out;
    while (com_out === ph)
    begin
      @(posedge mclk);
      #1;
    end
    ph = com_out;
    plen = 0;
    while (com_out === ph && plen < 1000)
    begin
      @(posedge mclk);
      #1;
      plen++;
    end
    chk("phase", plen, FRAME_T / N_COM * DIVP);
    wr_cfg(9'h084);
    disp_chk(1'b1);
    // keys in normal mode, then with scan rows given to segments
    wr_cfg(9'h000);
    rw(A_CLR, 8'h07);
    key_read(30'h0000_0800, 31'h0000_0800, 1'b1, "key_n");
    wr_cfg(9'h008);
    rw(A_CLR, 8'h07);
    key_read(30'h0000_0021, 31'h0000_0020, 1'b0, "key_k01");
    wr_cfg(9'h004);
    rw(A_CLR, 8'h07);
    key_read(30'h0000_0821, 31'h0000_0800, 1'b0, "key_k10");
    // key wakes sleep; a mode write while pending still lands
    wr_cfg(9'h003);
    #1 chk("osc_slp", osc_run, 0);
    rw(A_CLR, 8'h07);
    key_read(30'h2000_0000, 31'h6000_0000, 1'b1, "key_s");
    end_of_test();
  end
endmodule
